/* sens_regs.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef SENS_REGS_SVH
`define SENS_REGS_SVH

`define SENS_OFS_CTRL     8'h00
`define SENS_OFS_ROWS     8'h04
`define SENS_OFS_TRAIN    8'h08
`define SENS_OFS_STATUS   8'h0C

`define SENS_CTRL_EXT     0
`define SENS_CTRL_MODE12  1
`define SENS_CTRL_LANES   3:2

`define SENS_ROWS_RST     16'h0800
`define SENS_TRAIN_RST    12'h3A5
`define SENS_IDLE_CW      12'h200

`define SENS_BURST_LAST   7'h7F
`define SENS_FOT_LAST     8'h1F
`define SENS_LAST_BIT10   4'h9
`define SENS_LAST_BIT12   4'hB
`define SENS_LANES_4      2'h2

`define SENS_RESP_OKAY    2'h0
`define SENS_RESP_SLVERR  2'h2

`endif

/* sens_pkg.sv */
// Types shared by the exposure and readout design
package sens_pkg;

  typedef enum logic [1:0] {ST_IDLE, ST_FOT, ST_READ} seq_state_t;

  typedef logic [16:0][11:0] word_arr_t;

  typedef struct packed {
    logic        clk;
    logic        ctl;
    logic [15:0] data;
  } lvds_out_t;

  typedef struct packed {
    logic [1:0] zero_hi;
    logic       one9;
    logic       zero8;
    logic       inte2;
    logic       inte1;
    logic       frame_overhead_time;
    logic       row;
    logic       slot;
    logic       frame_valid_flag;
    logic       row_valid_flag;
    logic       pixel_valid_flag;
  } ctl_word_t;

  typedef struct packed {
    logic      [1:0] s;
  } sync_state_t;

  typedef struct packed {
    logic      [1:0] s1;
    logic      [1:0] s2;
  } sync2_state_t;

  typedef struct packed {
    word_arr_t  sh;
    logic [3:0] idx;
    lvds_out_t  lvds;
  } ser_state_t;

  typedef struct packed {
    logic        awrdy;
    logic        wrdy;
    logic        arrdy;
    logic        aw_have;
    logic [7:0]  aw_addr;
    logic        w_have;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        ext_en;
    logic        mode12;
    logic [1:0]  lanes;
    logic [15:0] rows;
    logic [11:0] train;
    seq_state_t  st;
    logic        exposing;
    logic        pend;
    logic        bits12;
    logic [1:0]  lsel;
    logic [3:0]  div;
    logic [7:0]  fot_cnt;
    logic [6:0]  pix;
    logic        in_gap;
    logic [2:0]  burst;
    logic [15:0] row;
    logic        pix_take;
    word_arr_t   words;
  } main_state_t;

endpackage : sens_pkg

/* sens_sync.sv */
// Two-flop synchroniser for the host strobes
`timescale 1ns/10ps
`default_nettype none

module sens_sync (
  // Clock and control
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [1:0] din,
  output logic      [1:0] dout
);

  sens_pkg::sync2_state_t q;
  sens_pkg::sync2_state_t d;

  always_comb begin
    d    = q;
    d.s1 = din;
    d.s2 = q.s1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign dout = q.s2;

endmodule : sens_sync

`default_nettype wire

/* sens_serializer.sv */
// LSB-first serializer for 16 data lanes, the control lane and the DDR clock
`timescale 1ns/10ps
`default_nettype none

module sens_serializer (
  // Clock and control
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                ce,
  // Parallel words, loaded at the start of each pixel period
  input  wire logic                load,
  input  wire sens_pkg::word_arr_t words,
  // Serial lanes
  output sens_pkg::lvds_out_t      lvds
);

  sens_pkg::ser_state_t q;
  sens_pkg::ser_state_t d;

  always_comb begin
    d = q;
    if (load) begin
      d.idx = 4'h0;
      for (int i = 0; i < 17; i++) begin
        d.sh[i] = words[i] >> 1;
      end
      d.lvds.data = {words[15][0], words[14][0], words[13][0], words[12][0],
                     words[11][0], words[10][0], words[9][0], words[8][0],
                     words[7][0], words[6][0], words[5][0], words[4][0],
                     words[3][0], words[2][0], words[1][0], words[0][0]};
      d.lvds.ctl  = words[16][0];
    end else begin
      d.idx = q.idx + 4'h1;
      for (int i = 0; i < 17; i++) begin
        d.sh[i] = q.sh[i] >> 1;
      end
      for (int i = 0; i < 16; i++) begin
        d.lvds.data[i] = q.sh[i][0];
      end
      d.lvds.ctl = q.sh[16][0];
    end
    // Bit 0 sits in the high phase: clock high on even bit indices
    d.lvds.clk = ~d.idx[0]; // R9
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign lvds = q.lvds;

endmodule : sens_serializer

`default_nettype wire

/* sens_readout.sv */
// Externally timed exposure sequencer and lane readout with AXI4-Lite registers
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "sens_regs.svh"

// Function
// R1: Strobes act only when external mode enabled
// R2: High exposure start level begins exposure
// R3: Frame request ends exposure, launches overhead, readout
// R4: Next exposure may start during readout
// R5: Host spaces start and request pulses
// R6: Sixteen data, one control, one clock lane
// R7: Forwarded clock is DDR, half bit rate
// R8: Control word same width, lockstep with data
// R9: LSB first, bit zero in clock high
// R10: Ten-bit mode: bit is tenth of pixel
// R11: Twelve-bit mode: bit is twelfth of pixel
// R12: Bursts of 128 pixels, one per period
// R13: One pixel period gap between bursts
// R14: Sixteen lanes: row in one burst
// R15: Eight lanes: two bursts, two gaps
// R16: Four lanes: four bursts, four gaps
// R17: Two lanes: eight bursts, eight gaps
// R18: Twelve-bit mode forces at most four lanes
// R19: Four-lane twelve-bit row takes 516 periods
// R20: Rows per frame programmable, default 2048
// R21: Control bits 0..2 flag pixel, row, frame
// R22: Idle control word equals 512
// R23: Training word on data lanes when invalid
// R24: Strobes synchronised before the sequencer
module sens_readout (
  // Clock, reset, enable
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 ce,
  // AXI4-Lite write
  input  wire logic [7:0]           awaddr,
  input  wire logic                 awvalid,
  output logic                      awready,
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  input  wire logic                 wvalid,
  output logic                      wready,
  output logic [1:0]                bresp,
  output logic                      bvalid,
  input  wire logic                 bready,
  // AXI4-Lite read
  input  wire logic [7:0]           araddr,
  input  wire logic                 arvalid,
  output logic                      arready,
  output logic [31:0]               rdata,
  output logic [1:0]                rresp,
  output logic                      rvalid,
  input  wire logic                 rready,
  // Host strobes, asynchronous
  input  wire logic                 exposure_start_input,
  input  wire logic                 frame_request_input,
  // Pixel source, one word per lane per pixel period
  input  wire logic [15:0][11:0]    pixel_in,
  output logic                      pix_take,
  // Serial lanes
  output sens_pkg::lvds_out_t       lvds
);

  sens_pkg::main_state_t q;
  sens_pkg::main_state_t d;
  logic      [1:0]                  strobe_s;
  logic                             start_s;
  logic                             req_s;
  logic                             tick;
  logic                             load;

  function automatic logic [3:0] last_bit(input logic b12);
    return b12 ? `SENS_LAST_BIT12 : `SENS_LAST_BIT10;
  endfunction : last_bit

  // Twelve-bit conversion is slow, so it never runs on more than four lanes
  function automatic logic [1:0] eff_lanes(input logic b12, input logic [1:0] code);
    return (b12 && code < `SENS_LANES_4) ? `SENS_LANES_4 : code; // R18
  endfunction : eff_lanes

  function automatic logic [11:0] fit_word(input logic b12, input logic [11:0] w);
    return b12 ? w : {2'h0, w[9:0]};
  endfunction : fit_word

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  sens_sync u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .din     ({frame_request_input, exposure_start_input}),
    .dout    (strobe_s)
  );

  assign start_s = strobe_s[0]; // R24
  assign req_s   = strobe_s[1]; // R24
  // One pixel period is ten or twelve bit times of aclk
  assign tick    = (q.div == last_bit(q.bits12)); // R10 R11
  assign load    = (q.div == 4'h0);

  always_comb begin
    logic [31:0]        cur;
    logic [2:0]         nb_last;
    logic [3:0]         mask;
    sens_pkg::ctl_word_t cw;
    cur     = '0;
    nb_last = '0;
    mask    = '0;
    cw      = '0;
    d       = q;

    // Write channel: address and data taken in either order
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    if (awvalid && q.awrdy) begin
      d.aw_have = 1'b1;
      d.aw_addr = awaddr;
    end
    if (wvalid && q.wrdy) begin
      d.w_have = 1'b1;
      d.w_data = wdata;
      d.w_strb = wstrb;
    end
    if (d.aw_have && d.w_have && !d.bvalid) begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = `SENS_RESP_OKAY;
      unique case (d.aw_addr)
        `SENS_OFS_CTRL: begin
          cur      = merge({28'h0, q.lanes, q.mode12, q.ext_en}, d.w_data, d.w_strb);
          d.ext_en = cur[`SENS_CTRL_EXT];
          d.mode12 = cur[`SENS_CTRL_MODE12];
          d.lanes  = cur[`SENS_CTRL_LANES];
        end
        `SENS_OFS_ROWS: begin
          cur    = merge({16'h0, q.rows}, d.w_data, d.w_strb);
          d.rows = cur[15:0]; // R20
        end
        `SENS_OFS_TRAIN: begin
          cur     = merge({20'h0, q.train}, d.w_data, d.w_strb);
          d.train = cur[11:0];
        end
        `SENS_OFS_STATUS: ;
        default: d.bresp = `SENS_RESP_SLVERR;
      endcase
    end
    d.awrdy = !d.aw_have && !d.bvalid;
    d.wrdy  = !d.w_have && !d.bvalid;

    // Read channel
    if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
    if (arvalid && q.arrdy) begin
      d.rvalid = 1'b1;
      d.rresp  = `SENS_RESP_OKAY;
      unique case (araddr)
        `SENS_OFS_CTRL:   d.rdata = {28'h0, q.lanes, q.mode12, q.ext_en};
        `SENS_OFS_ROWS:   d.rdata = {16'h0, q.rows};
        `SENS_OFS_TRAIN:  d.rdata = {20'h0, q.train};
        `SENS_OFS_STATUS: d.rdata = {q.row, 9'h0, q.lsel, q.bits12, q.pend, q.exposing, q.st};
        default: begin
          d.rdata = '0;
          d.rresp = `SENS_RESP_SLVERR;
        end
      endcase
    end
    d.arrdy = !d.rvalid;

    // Exposure: may start while an earlier frame is still read out
    if (q.ext_en && start_s && !q.exposing && !q.pend && q.st != sens_pkg::ST_FOT) begin
      d.exposing = 1'b1; // R1 R2 R4
    end
    if (q.ext_en && req_s && q.exposing) begin
      d.exposing = 1'b0; // R1 R3
      d.pend     = 1'b1;
    end

    // Pixel-period sequencer
    d.pix_take = 1'b0;
    d.div      = tick ? 4'h0 : q.div + 4'h1;
    nb_last    = 3'((4'h1 << q.lsel) - 4'h1); // R14 R15 R16 R17
    if (tick) begin
      unique case (q.st)
        sens_pkg::ST_IDLE: begin
          // Mode and lane count are frozen for the whole frame
          d.bits12 = q.mode12;
          d.lsel   = eff_lanes(q.mode12, q.lanes); // R18
          if (q.pend) begin
            d.pend    = 1'b0;
            d.st      = sens_pkg::ST_FOT; // R3
            d.fot_cnt = 8'h0;
          end
        end
        sens_pkg::ST_FOT: begin
          d.fot_cnt = q.fot_cnt + 8'h1;
          if (q.fot_cnt == `SENS_FOT_LAST) begin
            d.st     = sens_pkg::ST_READ; // R3
            d.in_gap = 1'b1;
            d.pix    = 7'h0;
            d.burst  = 3'h0;
            d.row    = 16'h0;
          end
        end
        sens_pkg::ST_READ: begin
          if (q.in_gap) begin
            d.in_gap = 1'b0; // R13
            d.pix    = 7'h0;
          end else if (q.pix == `SENS_BURST_LAST) begin
            d.in_gap = 1'b1; // R12 R13
            if (q.burst == nb_last) begin
              d.burst = 3'h0;
              if (q.row + 16'h1 >= q.rows) begin
                d.st     = sens_pkg::ST_IDLE; // R20
                d.in_gap = 1'b0;
              end else begin
                d.row = q.row + 16'h1;
              end
            end else begin
              d.burst = q.burst + 3'h1; // R15 R16 R17 R19
            end
          end else begin
            d.pix = q.pix + 7'h1; // R12
          end
        end
      endcase

      // Words for the next pixel period, from the state it runs in
      cw.one9  = 1'b1; // R22
      cw.pixel_valid_flag  = (d.st == sens_pkg::ST_READ) && !d.in_gap; // R21
      cw.row_valid_flag  = (d.st == sens_pkg::ST_READ); // R21
      cw.frame_valid_flag  = (d.st == sens_pkg::ST_READ); // R21
      cw.slot  = (d.st == sens_pkg::ST_READ) && d.in_gap;
      cw.row   = cw.slot && (d.burst == 3'h0);
      cw.frame_overhead_time   = (d.st == sens_pkg::ST_FOT);
      cw.inte1 = d.exposing && !cw.frame_overhead_time;
      d.pix_take = cw.pixel_valid_flag;
      // Fewer lanes: each lane copies the lowest active lane of its group
      mask     = 4'(4'hF << d.lsel);
      for (int i = 0; i < 16; i++) begin
        d.words[i] = cw.pixel_valid_flag ? fit_word(d.bits12, pixel_in[4'(i) & mask])
                             : fit_word(d.bits12, d.train); // R23
      end
      d.words[16] = cw; // R8
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q       <= '0;
      q.rows  <= `SENS_ROWS_RST; // R20
      q.train <= `SENS_TRAIN_RST;
      q.st    <= sens_pkg::ST_IDLE;
      q.words <= {`SENS_IDLE_CW, {16{`SENS_TRAIN_RST}}};
    end else if (ce) begin
      q <= d;
    end
  end

  // Serializer shifts one bit per aclk: DDR clock is half the bit rate
  sens_serializer u_ser (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .load    (load),
    .words   (q.words),
    .lvds    (lvds)
  ); // R6 R7 R9

  assign awready  = q.awrdy;
  assign wready   = q.wrdy;
  assign bvalid   = q.bvalid;
  assign bresp    = q.bresp;
  assign arready  = q.arrdy;
  assign rvalid   = q.rvalid;
  assign rdata    = q.rdata;
  assign rresp    = q.rresp;
  assign pix_take = q.pix_take;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_ext_gate: assert property ($rose(q.exposing) |-> $past(q.ext_en)) // R1
    else $error("exposure started with external mode off");
  chk_start_level: assert property (
    ce && q.ext_en && start_s && !q.exposing && !q.pend && q.st != sens_pkg::ST_FOT |=> q.exposing) // R2
    else $error("exposure start level not taken");
  chk_req_ends: assert property (ce && q.ext_en && req_s && q.exposing |=> !q.exposing && q.pend) // R3
    else $error("frame request did not end exposure");
  chk_fot_launch: assert property (ce && tick && q.pend && q.st == sens_pkg::ST_IDLE |=> q.st == sens_pkg::ST_FOT) // R3
    else $error("overhead not launched");
  chk_burst_end: assert property (
    ce && tick && q.st == sens_pkg::ST_READ && !q.in_gap && q.pix == `SENS_BURST_LAST
    |=> q.in_gap || q.st == sens_pkg::ST_IDLE) // R12
    else $error("burst longer than 128 pixels");
  chk_gap_one: assert property (ce && tick && q.in_gap && q.st == sens_pkg::ST_READ |=> !q.in_gap) // R13
    else $error("gap longer than one pixel period");
  chk_lanes_12: assert property (q.st == sens_pkg::ST_READ && q.bits12 |-> q.lsel >= `SENS_LANES_4) // R18
    else $error("twelve-bit readout on too many lanes");
  chk_idle_word: assert property (
    ce && tick && q.st == sens_pkg::ST_IDLE && !q.pend && !q.exposing ##1 !q.exposing
    |-> q.words[16] == `SENS_IDLE_CW) // R22
    else $error("idle control word wrong");
  // Only right after a tick: a training write lands mid-period
  chk_train_word: assert property (
    ce && tick ##1 !q.words[16][0] |-> q.words[0] == fit_word(q.bits12, q.train)) // R23
    else $error("training word missing");
  chk_bit_zero: assert property (ce && load |=> lvds.clk) // R9
    else $error("bit zero not in clock high phase");

  cov_frame_done: cover property ($fell(q.words[16][2]));
  cov_overlap: cover property (q.st == sens_pkg::ST_READ && q.exposing);
  cov_twelve: cover property (q.st == sens_pkg::ST_READ && q.bits12 && q.lsel == 2'h3);

endmodule : sens_readout

`default_nettype wire

/* sens_host_model.sv */
// Host receiver model: deserialises the control lane and data lanes 0 and 15, and drives the strobes
`timescale 1ns/10ps
`default_nettype none

module sens_host_model (
  // Clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // Lanes and what the bench expects on them
  input  wire sens_pkg::lvds_out_t lvds,
  input  wire logic [3:0]          nbits,
  input  wire logic [3:0]          lmask,
  input  wire logic [11:0]         train,
  // Strobes
  output logic                     exposure_start_input,
  output logic                     frame_request_input
);
  logic [11:0] sc, s0, sf, cw, d0, df, tm;
  logic [3:0]  cnt, nb_q;
  logic        locked, fv_q, ck_q;
  int          n_pixel_valid_flag, n_slot, n_row, n_frame, n_bad;

  task automatic clear;
    n_pixel_valid_flag = 0;
    n_slot = 0;
    n_row = 0;
    n_frame = 0;
    n_bad = 0;
    fv_q = 1'b0;
  endtask : clear

  // Request waits over a pixel period after the start strobe
  task automatic pulse(input logic req);
    if (req) repeat (12) @(posedge aclk);
    @(posedge aclk);
    frame_request_input  <= req;
    exposure_start_input <= !req;
    repeat (4) @(posedge aclk);
    frame_request_input  <= 1'b0;
    exposure_start_input <= 1'b0;
  endtask : pulse

  function automatic logic [11:0] take(input logic [11:0] s);
    return (nbits == 4'hC) ? s : {2'h0, s[11:2]};
  endfunction : take

  initial begin
    exposure_start_input = 1'b0;
    frame_request_input  = 1'b0;
    locked = 1'b0;
    clear();
  end

  // Alignment comes from the idle control word; lost on a mode change
  always @(posedge aclk) begin
    sc = {lvds.ctl, sc[11:1]};
    s0 = {lvds.data[0], s0[11:1]};
    sf = {lvds.data[15], sf[11:1]};
    cw = take(sc);
    d0 = take(s0);
    df = take(sf);
    tm = (nbits == 4'hC) ? train : {2'h0, train[9:0]};
    if (locked && lvds.clk === ck_q) n_bad++;
    ck_q = lvds.clk;
    cnt = cnt + 4'h1;
    if (locked && cnt == 4'h1 && lvds.clk !== 1'b1) n_bad++;
    if (!aresetn || nbits != nb_q) locked = 1'b0;
    nb_q = nbits;
    if (!locked && cw == 12'h200) begin
      locked = 1'b1;
      cnt = 4'h0;
    end
    if (cnt == nbits) cnt = 4'h0;
    if (locked && cnt == 4'h0) begin
      if (cw[9] !== 1'b1 || cw[11:10] !== 2'h0) begin
        locked = 1'b0;
      end else begin
        if (cw[0]) begin
          n_pixel_valid_flag++;
          if (d0 !== 12'h2C0 || df !== 12'h2C0 + {8'h00, lmask}) n_bad++;
        end else if (d0 !== tm || df !== tm) begin
          n_bad++;
        end
        n_slot += cw[3];
        n_row += cw[4];
        if (fv_q && !cw[2]) n_frame++;
        fv_q = cw[2];
      end
    end
  end
endmodule : sens_host_model
`default_nettype wire

/* test_sens_readout.sv */
// Self-checking bench for the exposure sequencer and lane readout
`timescale 1ns/10ps
`default_nettype none
`include "sens_regs.svh"

module test_sens_readout;
  logic                aclk, aresetn, ce, pix_take;
  logic [7:0]          awaddr, araddr;
  logic                awvalid, awready, wvalid, wready, bvalid, bready;
  logic                arvalid, arready, rvalid, rready;
  logic [31:0]         wdata, rdata;
  logic [3:0]          wstrb, nbits, lmask;
  logic [1:0]          bresp, rresp;
  logic [11:0]         train;
  logic [15:0][11:0]   pixel_in;
  logic                exposure_start_input, frame_request_input;
  sens_pkg::lvds_out_t lvds;
  int                  fail_count, checked, n_take;

  sens_readout u_sens_readout (.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .exposure_start_input, .frame_request_input, .pixel_in, .pix_take, .lvds);
  sens_host_model u_sens_host_model (.aclk, .aresetn, .lvds, .nbits, .lmask, .train,
    .exposure_start_input, .frame_request_input);

  always #5 aclk = ~aclk;
  always @(posedge aclk) if (pix_take === 1'b1) n_take++;

  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic expire(input string what);
    fail_count++;
    $display("Error %s expected done seen timeout", what);
    give_verdict();
  endtask : expire

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r,
                           input logic [3:0] s = 4'hF);
    int   n;
    logic aw, w;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    n = 0;
    aw = 1'b0;
    w = 1'b0;
    do begin
      @(posedge aclk);
      n++;
      aw = aw | (awready === 1'b1);
      w = w | (wready === 1'b1);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end while (!(aw && w) && n < 50);
    do begin
      @(posedge aclk);
      n++;
    end while (bvalid !== 1'b1 && n < 50);
    r = bresp;
    bready <= 1'b0;
    if (n >= 50) expire("write");
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (arready !== 1'b1 && n < 50);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (rvalid !== 1'b1 && n < 50);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 50) expire("read");
  endtask : axi_read

  // Re-aligning after a mode change can lock falsely once, so allow time
  task automatic wait_lock;
    int n;
    for (n = 0; n < 400 && (u_sens_host_model.locked !== 1'b1 || n < 40); n++) @(posedge aclk);
    if (n >= 400) expire("lock");
  endtask : wait_lock

  task automatic wait_frames(input int f);
    int n;
    for (n = 0; n < 40000 && u_sens_host_model.n_frame < f; n++) @(posedge aclk);
    if (n >= 40000) expire("frame end");
  endtask : wait_frames

  task automatic sc_regs;
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(`SENS_OFS_CTRL, d, r);
    check("ctrl reset", d, 32'h00000000);
    axi_read(`SENS_OFS_ROWS, d, r);
    check("rows reset", d, 32'h00000800);
    axi_write(`SENS_OFS_ROWS, 32'hFFFF1234, r, 4'h1);
    axi_read(`SENS_OFS_ROWS, d, r);
    check("rows byte write", d, 32'h00000834);
    axi_read(`SENS_OFS_TRAIN, d, r);
    check("train reset", d, {20'h00000, `SENS_TRAIN_RST});
    axi_write(`SENS_OFS_STATUS, 32'hFFFFFFFF, r);
    check("status write resp", r, `SENS_RESP_OKAY);
    axi_read(`SENS_OFS_STATUS, d, r);
    check("status read only", d[3:0], 4'h0);
    axi_write(8'h40, 32'h00000001, r);
    check("unmapped write resp", r, `SENS_RESP_SLVERR);
    axi_read(8'h40, d, r);
    check("unmapped read data", d, 32'h00000000);
    check("unmapped read resp", r, `SENS_RESP_SLVERR);
  endtask : sc_regs

  // Twenty frozen bit times keep the host's word alignment
  task automatic sc_hold;
    sens_pkg::lvds_out_t was;
    int                  moved;
    moved = 0;
    @(posedge aclk);
    ce <= 1'b0;
    @(posedge aclk);
    was = lvds;
    repeat (19) begin
      @(posedge aclk);
      if (lvds !== was) moved++;
    end
    ce <= 1'b1;
    check("lanes frozen", moved, 32'h00000000);
  endtask : sc_hold

  task automatic sc_ext_off;
    logic [31:0] d;
    logic [1:0]  r;
    wait_lock();
    u_sens_host_model.clear();
    u_sens_host_model.pulse(1'b0);
    u_sens_host_model.pulse(1'b1);
    axi_read(`SENS_OFS_STATUS, d, r);
    check("status ext off", d[3:0], 4'h0);
    repeat (300) @(posedge aclk);
    check("idle locked", {31'h00000000, u_sens_host_model.locked}, 32'h00000001);
    check("pixels ext off", u_sens_host_model.n_pixel_valid_flag, 32'h00000000);
    check("idle word errors", u_sens_host_model.n_bad, 32'h00000000);
  endtask : sc_ext_off

  task automatic run_frame(input logic [3:0] ctrl, input logic [15:0] rows, input int lsh, input logic again);
    logic [31:0] d;
    logic [1:0]  r;
    int          fr, px;
    fr = again ? 2 : 1;
    px = rows * (128 << lsh) * fr;
    axi_write(`SENS_OFS_ROWS, {16'h0000, rows}, r);
    axi_write(`SENS_OFS_CTRL, {28'h0000000, ctrl}, r);
    axi_read(`SENS_OFS_CTRL, d, r);
    check("ctrl readback", d, {28'h0000000, ctrl});
    nbits <= ctrl[1] ? 4'hC : 4'hA;
    lmask <= 4'(4'hF << lsh);
    wait_lock();
    u_sens_host_model.clear();
    n_take = 0;
    u_sens_host_model.pulse(1'b0);
    axi_read(`SENS_OFS_STATUS, d, r);
    check("exposing", d[2:0], 3'h4);
    u_sens_host_model.pulse(1'b1);
    axi_read(`SENS_OFS_STATUS, d, r);
    check("exposure ended", d[2], 1'b0);
    if (again) begin
      for (int k = 0; k < 4000 && u_sens_host_model.n_pixel_valid_flag == 0; k++) @(posedge aclk);
      if (u_sens_host_model.n_pixel_valid_flag == 0) expire("readout start");
      u_sens_host_model.pulse(1'b0);
      axi_read(`SENS_OFS_STATUS, d, r);
      check("start during readout", d[2:0], 3'h6);
      wait_frames(1);
      u_sens_host_model.pulse(1'b1);
    end
    wait_frames(fr);
    check("pixel words", u_sens_host_model.n_pixel_valid_flag, px);
    check("pixel takes", n_take, px);
    check("gap words", u_sens_host_model.n_slot, px / 128);
    check("row marks", u_sens_host_model.n_row, rows * fr);
    check("word errors", u_sens_host_model.n_bad, 32'h00000000);
    axi_read(`SENS_OFS_STATUS, d, r);
    check("back to idle", d[2:0], 3'h0);
  endtask : run_frame

  initial begin
    logic [1:0] r;
    aclk = 1'b0;
    aresetn = 1'b0;
    ce = 1'b1;
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
    nbits = 4'hA;
    lmask = 4'hF;
    train = `SENS_TRAIN_RST;
    for (int i = 0; i < 16; i++) pixel_in[i] = 12'h2C0 + 12'(i);
    fail_count = 0;
    checked = 0;
    n_take = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    sc_regs();
    sc_hold();
    sc_ext_off();
    run_frame(4'h1, 16'h0002, 0, 1'b1);
    run_frame(4'h5, 16'h0002, 1, 1'b0);
    run_frame(4'h9, 16'h0001, 2, 1'b0);
    run_frame(4'hD, 16'h0001, 3, 1'b0);
    axi_write(`SENS_OFS_TRAIN, 32'h00000C3A, r);
    train <= 12'hC3A;
    run_frame(4'h3, 16'h0001, 2, 1'b0);
    run_frame(4'hF, 16'h0001, 3, 1'b0);
    give_verdict();
  end
endmodule : test_sens_readout
`default_nettype wire
